// File: rtl/can_tx_buffer_control.sv
// Top: Wishbone slave, transmit buffers, priority arbiter and interrupts
`default_nettype none
module can_tx_buffer_control
  import can_tx_pkg::*;
(
  input wire logic clk_i,            // System clock, 50 MHz
  input wire logic rst_i,            // Synchronous reset, active high
  input wire logic wb_cyc_i,         // Wishbone cycle
  input wire logic wb_stb_i,         // Wishbone strobe
  input wire logic wb_we_i,          // Wishbone write enable
  input wire logic [7:0] wb_adr_i,   // Wishbone byte address
  input wire logic [3:0] wb_sel_i,   // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,  // Wishbone write data
  output logic [31:0] wb_dat_o,      // Wishbone read data
  output logic wb_ack_o,             // Wishbone acknowledge
  output logic irq_o,                // Interrupt, level
  output logic tx_start_o,           // Pulse: hand buffer to engine
  output logic [1:0] tx_buf_o,       // Buffer being handed over
  output tx_id_s tx_id_o,            // Identifier of handed buffer
  output logic tx_abort_o,           // Pulse: abort current send
  input wire logic eng_busy_i,       // Engine is sending
  input wire logic eng_done_i,       // Pulse: send finished
  input wire tx_result_s eng_res_i   // Result of finished send
);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } arb_state_e;

  arb_state_e state_r;
  logic wb_req, wb_wr, in_bufs, byte0;
  logic [1:0] buf_sel;
  logic [4:0] buf_reg;
  logic [7:0] buf_rdat [NUM_BUF];
  logic [NUM_BUF-1:0] pend, abort_req;
  logic [1:0] prio [NUM_BUF];
  tx_id_s ids [NUM_BUF];
  logic [NUM_BUF-1:0] res_vld;
  tx_result_s res [NUM_BUF];
  logic [1:0] cur_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
  logic engine_en_r;
  logic [31:0] rdat;

  // A request is acked one cycle after strobe; ack drops the next cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign byte0 = wb_sel_i[0];
  assign wb_wr = wb_req && wb_we_i && byte0;
  assign in_bufs = wb_adr_i < (BUF_STRIDE * 8'h03);
  assign buf_sel = (wb_adr_i >= (BUF_STRIDE * 8'h02)) ? 2'd2 :
                   (wb_adr_i >= BUF_STRIDE) ? 2'd1 : 2'd0;
  assign buf_reg = wb_adr_i[4:0];

  // ---------------------------------------------------------------
  // Buffers
  // ---------------------------------------------------------------
  // Result handed to a buffer that software aborts before hand-over
  localparam tx_result_s ABORT_RES = '{done: 1'b0, aborted: 1'b1, lost_arb: 1'b0, bus_err: 1'b0};

  // One parameterless instance per buffer keeps state fully independent
  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++) begin : g_buf
      logic wr_this, in_flight, idle_abt;
      assign wr_this = wb_wr && in_bufs && (buf_sel == 2'(g));
      // A buffer not yet handed over is aborted here at once, not by the engine
      assign in_flight = (state_r != ST_IDLE) && (cur_r == 2'(g));
      assign idle_abt = abort_req[g] && !in_flight;
      assign res_vld[g] = (eng_done_i && (state_r == ST_WAIT) && (cur_r == 2'(g))) || idle_abt;
      assign res[g] = idle_abt ? ABORT_RES : eng_res_i;
      can_tx_buf_regs u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .reg_i(buf_reg),
        .wr_i(wr_this),
        .wdat_i(wb_dat_i[7:0]),
        .res_i(res[g]),
        .res_vld_i(res_vld[g]),
        .rdat_o(buf_rdat[g]),
        .pend_o(pend[g]),
        .prio_o(prio[g]),
        .id_o(ids[g]),
        .abort_req_o(abort_req[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Priority selection
  // ---------------------------------------------------------------
  // Scan upward with >= so the higher index wins a tie
  logic [1:0] win_idx;
  logic win_vld;
  logic [1:0] win_prio;
  always_comb begin
    win_idx = 2'd0;
    win_vld = 1'b0;
    win_prio = 2'd0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (pend[i] && (!win_vld || prio[i] >= win_prio)) begin
        win_vld = 1'b1;
        win_prio = prio[i];
        win_idx = i[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Hand-over sequencer
  // ---------------------------------------------------------------
  // Priority only picks the buffer; the identifier is passed untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cur_r <= 2'd0;
      tx_start_o <= 1'b0;
      tx_buf_o <= 2'd0;
      tx_id_o <= '0;
      tx_abort_o <= 1'b0;
    end else begin
      tx_start_o <= 1'b0;
      tx_abort_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // A winner being aborted in this cycle must not be handed over
          if (engine_en_r && win_vld && !eng_busy_i && !abort_req[win_idx]) begin
            cur_r <= win_idx;
            tx_buf_o <= win_idx;
            tx_id_o <= ids[win_idx];
            tx_start_o <= 1'b1;
            state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          state_r <= ST_WAIT;
          if (abort_req[cur_r]) tx_abort_o <= 1'b1;
        end
        ST_WAIT: begin
          // A send that ends in this cycle needs no abort
          if (abort_req[cur_r] && !eng_done_i) tx_abort_o <= 1'b1;
          if (eng_done_i) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupts and engine enable
  // ---------------------------------------------------------------
  // Each buffer's own result is used, so a local abort and an engine
  // answer for another buffer in the same cycle are both recorded
  assign irq_set = {res_vld[2] && (res[2].aborted || res[2].bus_err),
                    res_vld[1] && (res[1].aborted || res[1].bus_err),
                    res_vld[0] && (res[0].aborted || res[0].bus_err),
                    res_vld[2] && res[2].done,
                    res_vld[1] && res[1].done,
                    res_vld[0] && res[0].done};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      engine_en_r <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      // Set wins over a write-one clear in the same cycle
      if (wb_wr && wb_adr_i == ADDR_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      if (wb_wr && wb_adr_i == ADDR_IRQ_MASK) irq_mask_r <= wb_dat_i[IRQ_W-1:0];
      if (wb_wr && wb_adr_i == ADDR_ENGINE) engine_en_r <= wb_dat_i[0];
      irq_o <= |((irq_stat_r | irq_set) & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Read data and acknowledge
  // ---------------------------------------------------------------
  assign rdat = in_bufs ? {24'h00_0000, buf_rdat[buf_sel]} :
                (wb_adr_i == ADDR_IRQ_STAT) ? {26'h000_0000, irq_stat_r} :
                (wb_adr_i == ADDR_IRQ_MASK) ? {26'h000_0000, irq_mask_r} :
                (wb_adr_i == ADDR_ENGINE) ? {31'h0000_0000, engine_en_r} :
                UNMAPPED_DATA;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) wb_dat_o <= rdat;
    end
  end
endmodule : can_tx_buffer_control
`default_nettype wire

// File: rtl/can_tx_pkg.sv
// Package: register map, field positions and carriers for the CAN transmit buffer block
`default_nettype none
package can_tx_pkg;
  localparam int NUM_BUF = 3;
  localparam int BUF_W = 2;
  // Per-buffer byte stride and register indexes inside a buffer group
  localparam logic [7:0] BUF_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_SIDH = 5'h04;
  localparam logic [4:0] OFF_SIDL = 5'h08;
  localparam logic [4:0] OFF_EIDH = 5'h0C;
  localparam logic [4:0] OFF_EIDL = 5'h10;
  // Shared registers above the buffer groups
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h64;
  localparam logic [7:0] ADDR_ENGINE = 8'h68;
  // Control register fields
  localparam int CTL_ABT = 6;
  localparam int CTL_LARB = 5;
  localparam int CTL_ERR = 4;
  localparam int CTL_REQ = 3;
  localparam logic [7:0] CTL_WMASK = 8'h0B;
  // Identifier low byte fields
  localparam int SIDL_EXT = 3;
  localparam logic [7:0] SIDL_WMASK = 8'hEB;
  // Interrupt status layout: one done bit and one fault bit per buffer
  localparam int IRQ_W = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic ext;            // Extended format
    logic [28:0] ident;   // Identifier, right aligned
  } tx_id_s;

  typedef struct packed {
    logic done;           // Message sent
    logic aborted;        // Aborted before hand-over or during send
    logic lost_arb;       // Arbitration lost
    logic bus_err;        // Bus error during send
  } tx_result_s;
endpackage : can_tx_pkg
`default_nettype wire

// File: rtl/can_tx_buf_regs.sv
// One transmit buffer: control, identifier registers and status flags
`default_nettype none
module can_tx_buf_regs
  import can_tx_pkg::*;
(
  input wire logic clk_i,          // System clock
  input wire logic rst_i,          // Synchronous reset
  input wire logic [4:0] reg_i,    // Register index within buffer
  input wire logic wr_i,           // Write strobe for this buffer
  input wire logic [7:0] wdat_i,   // Write data
  input wire tx_result_s res_i,    // Result for this buffer, from engine or local abort
  input wire logic res_vld_i,      // Result valid pulse
  output logic [7:0] rdat_o,       // Read data
  output logic pend_o,             // Send request pending
  output logic [1:0] prio_o,       // Priority level
  output tx_id_s id_o,             // Identifier to send
  output logic abort_req_o         // Software abort request pulse
);
  logic [7:0] ctl_r, sidh_r, sidl_r, eidh_r, eidl_r;
  logic [7:0] ctl_nxt;
  logic wr_ctl, req_set, req_clr;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wr_ctl = wr_i && (reg_i == OFF_CTRL);
  assign req_set = wr_ctl && wdat_i[CTL_REQ] && !ctl_r[CTL_REQ];
  assign req_clr = wr_ctl && !wdat_i[CTL_REQ] && ctl_r[CTL_REQ];
  assign abort_req_o = req_clr;

  // Control next value; engine results win over the flag clear of a new request
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = (ctl_r & ~CTL_WMASK) | (wdat_i & CTL_WMASK);
      ctl_nxt[CTL_REQ] = ctl_r[CTL_REQ] | wdat_i[CTL_REQ]; // Clear finishes via abort
    end
    if (req_set) begin
      ctl_nxt[CTL_ABT] = 1'b0;
      ctl_nxt[CTL_LARB] = 1'b0;
      ctl_nxt[CTL_ERR] = 1'b0;
    end
    if (res_vld_i) begin
      if (res_i.done) ctl_nxt[CTL_REQ] = 1'b0;
      if (res_i.aborted) begin
        ctl_nxt[CTL_ABT] = 1'b1;
        ctl_nxt[CTL_REQ] = 1'b0;
      end
      if (res_i.lost_arb) ctl_nxt[CTL_LARB] = 1'b1;
      if (res_i.bus_err) ctl_nxt[CTL_ERR] = 1'b1;
    end
  end

  // Register storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= RESET_BYTE;
      sidh_r <= RESET_BYTE;
      sidl_r <= RESET_BYTE;
      eidh_r <= RESET_BYTE;
      eidl_r <= RESET_BYTE;
    end else begin
      ctl_r <= ctl_nxt;
      if (wr_i && reg_i == OFF_SIDH) sidh_r <= wdat_i;
      if (wr_i && reg_i == OFF_SIDL) sidl_r <= wdat_i & SIDL_WMASK;
      if (wr_i && reg_i == OFF_EIDH) eidh_r <= wdat_i;
      if (wr_i && reg_i == OFF_EIDL) eidl_r <= wdat_i;
    end
  end

  // ---------------------------------------------------------------
  // Read mux and identifier assembly
  // ---------------------------------------------------------------
  assign rdat_o = (reg_i == OFF_CTRL) ? ctl_r :
                  (reg_i == OFF_SIDH) ? sidh_r :
                  (reg_i == OFF_SIDL) ? sidl_r :
                  (reg_i == OFF_EIDH) ? eidh_r :
                  (reg_i == OFF_EIDL) ? eidl_r : RESET_BYTE;
  assign pend_o = ctl_r[CTL_REQ];
  assign prio_o = ctl_r[1:0];
  assign id_o.ext = sidl_r[SIDL_EXT];
  // Standard bits become the top eleven of an extended identifier
  assign id_o.ident = sidl_r[SIDL_EXT] ?
    {sidh_r, sidl_r[7:5], sidl_r[1:0], eidh_r, eidl_r} :
    {18'h0_0000, sidh_r, sidl_r[7:5]};
endmodule : can_tx_buf_regs
`default_nettype wire

// File: verif/can_tx_chk.sv
// Checker: port-level assertions for the transmit buffer block
`default_nettype none
module can_tx_chk
  import can_tx_pkg::*;
(
  input wire logic clk_i,        // Clock
  input wire logic rst_i,        // Reset
  input wire logic wb_cyc_i,     // Cycle
  input wire logic wb_stb_i,     // Strobe
  input wire logic wb_ack_o,     // Ack
  input wire logic tx_start_o,   // Hand-over
  input wire logic [1:0] tx_buf_o, // Buffer
  input wire tx_id_s tx_id_o,    // Identifier
  input wire logic tx_abort_o,   // Abort
  input wire logic eng_busy_i    // Engine busy
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A new bus request is one not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_hand;
    tx_start_o ##1 !tx_start_o;
  endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_start_pulse; tx_start_o |-> s_hand; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_no_busy; tx_start_o |-> !$past(eng_busy_i); endproperty
  a_no_busy: assert property (p_no_busy) else $error("start while busy");
  property p_buf; tx_start_o |-> tx_buf_o < 2'h3; endproperty
  a_buf: assert property (p_buf) else $error("bad buffer index");
  property p_std; tx_start_o && !tx_id_o.ext |-> tx_id_o.ident[28:11] == 18'h0; endproperty
  a_std: assert property (p_std) else $error("standard id too wide");
  // Identifier may only move at a hand-over, so priority cannot touch it
  property p_hold; !tx_start_o |-> $stable(tx_id_o) && $stable(tx_buf_o); endproperty
  a_hold: assert property (p_hold) else $error("id moved");
  property p_abt_pulse; tx_abort_o |=> !tx_abort_o; endproperty
  a_abt_pulse: assert property (p_abt_pulse) else $error("abort too long");
  property p_abt_fly; tx_abort_o |-> eng_busy_i; endproperty
  a_abt_fly: assert property (p_abt_fly) else $error("abort when idle");
endmodule : can_tx_chk
bind can_tx_buffer_control can_tx_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_start_o(tx_start_o),
  .tx_buf_o(tx_buf_o), .tx_id_o(tx_id_o), .tx_abort_o(tx_abort_o), .eng_busy_i(eng_busy_i));
`default_nettype wire

// File: verif/can_engine_model.sv
// Partner: behavioural transmit engine answering hand-overs after a delay
`default_nettype none
module can_engine_model
  import can_tx_pkg::*;
(
  input wire logic clk_i,        // Clock
  input wire logic rst_i,        // Reset
  input wire logic start_i,      // Hand-over
  input wire logic abort_i,      // Abort
  input wire tx_result_s res_i,  // Outcome to report
  input wire logic [7:0] dly_i,  // Send cycles
  output logic busy_o,           // Sending
  output logic done_o,           // Finished pulse
  output tx_result_s res_o       // Outcome
);
  logic [7:0] cnt_r;
  logic abt_r;
  // One frame at a time; outcome toggles outside the pulse so stale data shows
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    res_o <= ~res_o;
    if (rst_i) begin
      busy_o <= 1'b0;
      abt_r <= 1'b0;
      res_o <= 4'h0;
    end else if (!busy_o && start_i) begin
      busy_o <= 1'b1;
      cnt_r <= dly_i;
      abt_r <= 1'b0;
    end else if (busy_o) begin
      cnt_r <= cnt_r - 8'h01;
      if (abort_i) abt_r <= 1'b1;
      if (cnt_r == 8'h00) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        res_o <= (abt_r || abort_i) ? tx_result_s'(4'h4) : res_i;
      end
    end
  end
endmodule : can_engine_model
`default_nettype wire

// File: verif/test_can_tx_buffer_control.sv
// Testbench: registers, priority order, identifiers, abort, faults, interrupt
`default_nettype none
module test_can_tx_buffer_control
  import can_tx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic ack, irq, start, abort, busy, done;
  logic [7:0] adr = 8'h00, dly = 8'h04;
  logic [31:0] wdat = 32'h0, rdat;
  logic [1:0] buf_o;
  tx_id_s id;
  tx_result_s res = 4'h8, eres;
  int error_cnt = 0, n_tests = 0, n_abt = 0, n_done = 0;
  logic [1:0] bq[$];
  tx_id_s iq[$];
  always #10 clk_i = ~clk_i;
  can_tx_buffer_control DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .tx_start_o(start), .tx_buf_o(buf_o), .tx_id_o(id),
    .tx_abort_o(abort), .eng_busy_i(busy), .eng_done_i(done), .eng_res_i(eres));
  can_engine_model u_eng (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .abort_i(abort),
    .res_i(res), .dly_i(dly), .busy_o(busy), .done_o(done), .res_o(eres));
  // Pulses are caught mid-cycle where they are settled
  always @(negedge clk_i) begin
    if (start === 1'b1) bq.push_back(buf_o);
    if (start === 1'b1) iq.push_back(id);
    if (abort === 1'b1) n_abt++;
    if (done === 1'b1) n_done++;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Classic cycle: ack and data are taken at the rising edge, release right after it
  task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 0, 1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, q, exp);
  endtask : rdc
  task automatic wdone(input int k);
    for (int n = 0; n < 300 && n_done < k; n++) @(negedge clk_i);
    chk("done", n_done >= k, 1);
  endtask : wdone
  // Expected identifier built from the byte layout
  function automatic tx_id_s eid(input logic [7:0] h, l, eh, el);
    eid.ext = l[3];
    eid.ident = l[3] ? {h, l[7:5], l[1:0], eh, el} : {18'h0, h, l[7:5]};
  endfunction : eid
  task automatic t_regs;
    rdc("ctrl0", 8'h00, 8'h00);
    wr(8'h08, 8'hFF);
    rdc("sidl0", 8'h08, 8'hEB);
    wr(8'h40, 8'hF7);
    rdc("ctrl2", 8'h40, 8'h03);
    wr(8'h2C, 8'h5A);
    rdc("eidh1", 8'h2C, 8'h5A);
    wr(8'h30, 8'hC3);
    rdc("eidl1", 8'h30, 8'hC3);
    wr(8'h7C, 8'h55);
    rdc("unmapped", 8'h7C, 8'h00);
  endtask : t_regs
  // Requests queue while the engine is off; ties go to the higher buffer
  task automatic t_order;
    logic [7:0] h[3] = '{8'h81, 8'h5A, 8'hFF}, l[3] = '{8'hA3, 8'h4A, 8'hE3};
    logic [7:0] p[3] = '{8'h0B, 8'h09, 8'h09};
    logic [1:0] ord[3] = '{2'h0, 2'h2, 2'h1};
    for (int b = 0; b < 3; b++) begin
      wr(8'h20 * b + 8'h04, h[b]);
      wr(8'h20 * b + 8'h08, l[b]);
      wr(8'h20 * b + 8'h0C, 8'hBE);
      wr(8'h20 * b + 8'h10, 8'hEF);
      wr(8'h20 * b, p[b]);
    end
    wr(8'h68, 8'h01);
    wdone(3);
    for (int k = 0; k < 3; k++) begin
      chk("order", bq[k], ord[k]);
      chk("ident", iq[k], eid(h[ord[k]], l[ord[k]], 8'hBE, 8'hEF));
      rdc("ctrl", 8'h20 * ord[k], p[ord[k]] & 8'h03);
    end
    chk("irq masked", irq, 0);
    wr(8'h64, 8'h3F);
    @(negedge clk_i);
    chk("irq", irq, 1);
    rdc("status", 8'h60, 8'h07);
    wr(8'h60, 8'h07);
    @(negedge clk_i);
    chk("irq clear", irq, 0);
  endtask : t_order
  task automatic t_abort;
    dly <= 8'h28;
    wr(8'h20, 8'h08);
    wr(8'h20, 8'h00);
    wdone(4);
    chk("abort pulse", n_abt, 1);
    rdc("ctrl1 abt", 8'h20, 8'h40);
    rdc("status", 8'h60, 8'h10);
    wr(8'h60, 8'h10);
    dly <= 8'h14;
    wr(8'h20, 8'h08);
    rdc("ctrl1 req", 8'h20, 8'h08);
    wdone(5);
    rdc("ctrl1 sent", 8'h20, 8'h00);
    // Abort of a buffer that was never handed over
    wr(8'h68, 8'h00);
    wr(8'h40, 8'h08);
    wr(8'h40, 8'h00);
    rdc("ctrl2 idle abt", 8'h40, 8'h40);
    rdc("status idle abt", 8'h60, 8'h22);
    chk("no hand-over", bq.size(), 5);
    chk("no engine abort", n_abt, 1);
    wr(8'h60, 8'h3F);
    wr(8'h68, 8'h01);
  endtask : t_abort
  task automatic t_fault;
    res <= 4'h3;
    wr(8'h00, 8'h0B);
    wdone(6);
    res <= 4'h8;
    wdone(7);
    rdc("ctrl0 fault", 8'h00, 8'h33);
  endtask : t_fault
  task automatic results;
    $display("Checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_order();
    t_abort();
    t_fault();
    results();
  end
  // Whole run is well under two thousand cycles
  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule : test_can_tx_buffer_control
`default_nettype wire
